// ===== rtl/hrc_pkg.sv
// constants and carrier types of the counter reset and hold control
package hrc_pkg;

  // count and measurement width
  localparam int CW = 20;

  // configuration codes held in the control register
  localparam logic [2:0] CFG_ONE   = 3'h0;
  localparam logic [2:0] CFG_TWO   = 3'h1;
  localparam logic [2:0] CFG_TOTAL = 3'h2;
  localparam logic [2:0] CFG_BATCH = 3'h3;
  localparam logic [2:0] CFG_DUAL  = 3'h4;
  localparam logic [2:0] CFG_TACHO = 3'h5;

  // counting direction codes
  localparam logic [1:0] DIR_UP   = 2'h0;
  localparam logic [1:0] DIR_DOWN = 2'h1;
  localparam logic [1:0] DIR_UPDN = 2'h2;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_SET1   = 8'h04;
  localparam logic [7:0] ADDR_SET2   = 8'h08;
  localparam logic [7:0] ADDR_PV     = 8'h0c;
  localparam logic [7:0] ADDR_AUX    = 8'h10;
  localparam logic [7:0] ADDR_PVB    = 8'h14;
  localparam logic [7:0] ADDR_DUAL   = 8'h18;
  localparam logic [7:0] ADDR_TACHO  = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // values after reset
  localparam logic [31:0]   CTRL_RST = 32'h0000_0080;
  localparam logic [CW-1:0] SET1_RST = 20'h0000a;
  localparam logic [CW-1:0] SET2_RST = 20'h00014;

  // tachometer gate time and its cycle count
  localparam int CLK_PERIOD_NS = 100;
  localparam int TACHO_GATE_MS = 100;
  localparam int GATE_CYC      = TACHO_GATE_MS * 1000000 / CLK_PERIOD_NS;

  // number of pin inputs passing the synchroniser
  localparam int NIN = 5;

  // pin inputs after synchronisation
  typedef struct packed {
    logic key;
    logic rst2;
    logic rst1;
    logic cnt_b;
    logic cnt_a;
  } hrc_pins_t;

  // control register layout
  typedef struct packed {
    logic [20:0] rsvd;
    logic        dual_sub;
    logic        omode2;
    logic        omode1;
    logic        alloc2;
    logic        alloc1;
    logic        disp_aux;
    logic [1:0]  dir;
    logic [2:0]  cfg;
  } hrc_ctrl_t;

endpackage

// ===== rtl/hrc_sync_edge.sv
// two-flop synchroniser with level and rising edge per bit
`timescale 1ns/100ps
module hrc_sync_edge #(
  parameter int W = 5
) (
  input  wire logic         ref_clk_i, // system clock
  input  wire logic         rst_i,     // synchronous reset, high
  input  wire logic [W-1:0] d_i,       // asynchronous pins
  output logic      [W-1:0] lvl_o,     // synchronised level
  output logic      [W-1:0] rise_o     // one-cycle rising edge
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      logic prev_r;
      // first flop feeds only the second one
      always_ff @(posedge ref_clk_i)
      begin
        if (rst_i)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end
        else
        begin
          meta_r <= d_i[g];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end
      assign lvl_o[g]  = sync_r;
      assign rise_o[g] = sync_r & ~prev_r;
    end
  endgenerate

endmodule

// ===== rtl/hrc_top.sv
// reset and hold control of a preset counter and tachometer
//
// Overview of operation
// - as a tachometer only count input a, reset 1 and the key are used.
// - as a tachometer reset 1 freezes the measured value and outputs.
// - as a tachometer the reset indicator is lit while the hold lasts.
// - as a tachometer each output acts by its mode once a set is reached.
// - the reset indicator is lit while reset 1 or the reset key is on.
// - in 1- or 2-stage use the key clears present value and outputs.
// - in total use the key clears value and outputs, and the total if shown.
// - in batch use the key clears the value and stage 2 output only.
// - in batch use with the batch shown the key clears all of them.
// - in dual use the key clears both values, the sum and all outputs.
// - as a tachometer the key holds instead of clearing anything.
// - each physical output may be allocated to stage 1 or stage 2.
// - reset loads zero, or with direction down set 1 (set 2 in 2-stage use).
// - outside dual and tachometer use no counting happens while reset 1 is on.
`timescale 1ns/100ps
module hrc_top #(
  parameter int GATE_CYC = hrc_pkg::GATE_CYC
) (
  input  wire logic        ref_clk_i,         // 10 MHz clock
  input  wire logic        rst_i,             // synchronous reset, high
  input  wire logic        count_in_a_i,      // count pin a
  input  wire logic        count_in_b_i,      // count pin b or direction
  input  wire logic        reset1_i,          // reset 1 pin, high active
  input  wire logic        reset2_i,          // reset 2 pin, high active
  input  wire logic        reset_key_i,       // front reset key, high
  output logic             ctrl_out_stage1_o, // physical output 1
  output logic             ctrl_out_stage2_o, // physical output 2
  output logic             reset_ind_o,       // reset indicator
  input  wire logic [7:0]  paddr_i,           // apb address
  input  wire logic        psel_i,            // apb select
  input  wire logic        penable_i,         // apb enable
  input  wire logic        pwrite_i,          // apb direction
  input  wire logic [31:0] pwdata_i,          // apb write data
  output logic [31:0]      prdata_o,          // apb read data
  output logic             pready_o,          // apb ready
  output logic             pslverr_o          // apb error
);

  localparam int CW = hrc_pkg::CW;

  hrc_pkg::hrc_pins_t lvl;
  hrc_pkg::hrc_pins_t rise;
  hrc_pkg::hrc_ctrl_t ctrl_r;
  logic [CW-1:0]      set1_r;
  logic [CW-1:0]      set2_r;
  logic [CW-1:0]      pv_r;
  logic [CW-1:0]      pvb_r;
  logic [CW-1:0]      aux_r;
  logic [CW-1:0]      meas_r;
  logic [CW-1:0]      acc_r;
  logic [19:0]        gate_r;
  logic               st1_r;
  logic               st2_r;
  logic               ctrl_out_stage1_r;
  logic               ctrl_out_stage2_r;
  logic               ind_r;
  logic [31:0]        prdata_r;
  logic               err_r;

  // all pins pass two flops before use
  hrc_sync_edge #(
    .W (hrc_pkg::NIN)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       ({reset_key_i, reset2_i, reset1_i, count_in_b_i,
                 count_in_a_i}),
    .lvl_o     (lvl),
    .rise_o    (rise)
  );

  // configuration decode
  logic is_tacho;
  logic is_dual;
  logic is_batch;
  logic is_total;
  logic is_one;
  logic is_two;
  assign is_tacho = ctrl_r.cfg == hrc_pkg::CFG_TACHO;
  assign is_dual  = ctrl_r.cfg == hrc_pkg::CFG_DUAL;
  assign is_batch = ctrl_r.cfg == hrc_pkg::CFG_BATCH;
  assign is_total = ctrl_r.cfg == hrc_pkg::CFG_TOTAL;
  assign is_one   = ctrl_r.cfg == hrc_pkg::CFG_ONE;
  assign is_two   = ctrl_r.cfg == hrc_pkg::CFG_TWO;

  // tachometer ignores pin b and reset 2
  logic r1;
  logic r2;
  logic rise_b;
  logic key_p;
  assign r1     = lvl.rst1;
  assign r2     = lvl.rst2 & ~is_tacho;
  assign rise_b = rise.cnt_b & ~is_tacho;
  assign key_p  = rise.key;

  // clear and hold conditions; a clear always beats a count
  logic clr_pv;
  logic clr_pvb;
  logic clr_aux;
  logic clr_st1;
  logic clr_st2;
  logic hold;
  assign clr_pv  = ~is_tacho & (r1 | key_p);
  assign clr_pvb = is_dual & (r2 | key_p);
  assign clr_aux = (is_total | is_batch)
                   & (r2 | (key_p & ctrl_r.disp_aux));
  assign clr_st2 = ~is_tacho & (key_p | (r1 & ~is_dual));
  assign clr_st1 = ~is_tacho
                   & ((key_p & (~is_batch | ctrl_r.disp_aux))
                   | (r1 & ~is_batch & ~is_dual)
                   | (r2 & is_batch));
  assign hold    = is_tacho & (r1 | lvl.key);

  // direction and the value loaded on reset
  logic          dn;
  logic [CW-1:0] rstv;
  logic [CW-1:0] pv_step;
  logic          cnt_a;
  logic          batch_hit;
  assign dn = ~is_dual & ((ctrl_r.dir == hrc_pkg::DIR_DOWN)
              | ((ctrl_r.dir == hrc_pkg::DIR_UPDN) & lvl.cnt_b));
  assign rstv = (ctrl_r.dir == hrc_pkg::DIR_DOWN)
                ? (is_two ? set2_r : set1_r) : '0;
  assign pv_step   = dn ? pv_r - 1'b1 : pv_r + 1'b1;
  assign cnt_a     = rise.cnt_a & ~is_tacho;
  assign batch_hit = is_batch & cnt_a & ~clr_pv
                     & (pv_step == (dn ? '0 : set2_r));

  // present value of channel a
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      pv_r <= '0;
    else if (clr_pv)
      pv_r <= rstv;
    else if (batch_hit)
      pv_r <= rstv;
    else if (cnt_a)
      pv_r <= pv_step;
  end

  // present value of channel b, dual use only
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      pvb_r <= '0;
    else if (clr_pvb)
      pvb_r <= '0;
    else if (is_dual & rise_b)
      pvb_r <= pvb_r + 1'b1;
  end

  // total or batch count
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      aux_r <= '0;
    else if (clr_aux)
      aux_r <= '0;
    else if ((is_total & cnt_a & ~clr_pv) | batch_hit)
      aux_r <= aux_r + 1'b1;
  end

  // tachometer gate; counting runs through a hold, only the result freezes
  logic gate_end;
  assign gate_end = gate_r == 20'(GATE_CYC - 1);
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      gate_r <= '0;
      acc_r  <= '0;
      meas_r <= '0;
    end
    else if (gate_end)
    begin
      gate_r <= '0;
      acc_r  <= '0;
      if (~hold & is_tacho)
        meas_r <= acc_r;
    end
    else
    begin
      gate_r <= gate_r + 1'b1;
      if (rise.cnt_a)
        acc_r <= acc_r + 1'b1;
    end
  end

  // comparison against the set values
  logic [CW-1:0] dual_v;
  logic [CW-1:0] val;
  logic          hit1;
  logic          hit2;
  assign dual_v = ctrl_r.dual_sub ? pv_r - pvb_r : pv_r + pvb_r;
  assign val    = is_dual ? dual_v : pv_r;
  always_comb
  begin
    hit1 = 1'b0;
    hit2 = 1'b0;
    if (is_tacho)
    begin
      hit1 = meas_r >= set1_r;
      hit2 = meas_r >= set2_r;
    end
    else if (is_batch)
    begin
      hit1 = aux_r >= set1_r;
      hit2 = batch_hit;
    end
    else if (dn)
    begin
      hit1 = ~is_one & (val <= set1_r);
      hit2 = val == '0;
    end
    else
    begin
      hit1 = ~is_one & (val >= set1_r);
      hit2 = val >= (is_one ? set1_r : set2_r);
    end
  end

  // stage 1 state: mode 0 latches, mode 1 follows the comparison
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      st1_r <= 1'b0;
    else if (clr_st1)
      st1_r <= 1'b0;
    else if (~hold)
      st1_r <= ctrl_r.omode1 ? hit1 : (st1_r | hit1);
  end

  // stage 2 state, same scheme
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      st2_r <= 1'b0;
    else if (clr_st2)
      st2_r <= 1'b0;
    else if (~hold)
      st2_r <= ctrl_r.omode2 ? hit2 : (st2_r | hit2);
  end

  // output allocation and reset indicator, registered
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_out_stage1_r <= 1'b0;
      ctrl_out_stage2_r <= 1'b0;
      ind_r  <= 1'b0;
    end
    else
    begin
      ctrl_out_stage1_r <= ctrl_r.alloc1 ? st2_r : st1_r;
      ctrl_out_stage2_r <= ctrl_r.alloc2 ? st2_r : st1_r;
      ind_r  <= r1 | lvl.key;
    end
  end
  assign ctrl_out_stage1_o = ctrl_out_stage1_r;
  assign ctrl_out_stage2_o = ctrl_out_stage2_r;
  assign reset_ind_o       = ind_r;

  // apb writes take effect in the access phase
  logic wr_en;
  assign wr_en = psel_i & penable_i & pwrite_i;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= hrc_pkg::CTRL_RST;
      set1_r <= hrc_pkg::SET1_RST;
      set2_r <= hrc_pkg::SET2_RST;
    end
    else if (wr_en)
    begin
      if (paddr_i == hrc_pkg::ADDR_CTRL)
        ctrl_r <= {21'h0, pwdata_i[10:0]};
      if (paddr_i == hrc_pkg::ADDR_SET1)
        set1_r <= pwdata_i[CW-1:0];
      if (paddr_i == hrc_pkg::ADDR_SET2)
        set2_r <= pwdata_i[CW-1:0];
    end
  end

  // read decode; unmapped offsets answer with an error
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb
  begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    unique case (paddr_i)
      hrc_pkg::ADDR_CTRL:   rd_val = ctrl_r;
      hrc_pkg::ADDR_SET1:   rd_val = {12'h0, set1_r};
      hrc_pkg::ADDR_SET2:   rd_val = {12'h0, set2_r};
      hrc_pkg::ADDR_PV:     rd_val = {12'h0, pv_r};
      hrc_pkg::ADDR_AUX:    rd_val = {12'h0, aux_r};
      hrc_pkg::ADDR_PVB:    rd_val = {12'h0, pvb_r};
      hrc_pkg::ADDR_DUAL:   rd_val = {12'h0, dual_v};
      hrc_pkg::ADDR_TACHO:  rd_val = {12'h0, meas_r};
      hrc_pkg::ADDR_STATUS: rd_val = {26'h0, hold, ind_r, ctrl_out_stage2_r,
                                      ctrl_out_stage1_r, st2_r, st1_r};
      default:              rd_ok  = 1'b0;
    endcase
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      prdata_r <= 32'h0;
      err_r    <= 1'b0;
    end
    else if (psel_i & ~penable_i)
    begin
      prdata_r <= pwrite_i ? 32'h0 : rd_val;
      err_r    <= ~rd_ok;
    end
  end
  assign prdata_o  = prdata_r;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & err_r;

  // checks on the behaviour above
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_key_counter;
    key_p && !is_tacho;
  endsequence
  sequence s_hold_two;
    hold ##1 hold;
  endsequence

  property p_tacho_no_b;
    is_tacho && $past(is_tacho) |-> $stable(pvb_r);
  endproperty
  a_tacho_no_b: assert property (p_tacho_no_b)
    else $error("channel b moved in tachometer use");

  property p_hold_freeze;
    s_hold_two |-> $stable(meas_r) && $stable(st1_r) && $stable(st2_r);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("hold did not freeze value or outputs");

  property p_ind;
    (r1 || lvl.key) |=> reset_ind_o;
  endproperty
  a_ind: assert property (p_ind)
    else $error("reset indicator off during reset");

  property p_key_clear;
    s_key_counter |=> pv_r == $past(rstv) && !st2_r;
  endproperty
  a_key_clear: assert property (p_key_clear)
    else $error("key did not clear value and output");

  property p_total_clear;
    key_p && is_total && ctrl_r.disp_aux |=> aux_r == '0 && !st1_r;
  endproperty
  a_total_clear: assert property (p_total_clear)
    else $error("total not cleared while shown");

  property p_batch_keep;
    key_p && is_batch && !ctrl_r.disp_aux && !r2
      |=> $stable(aux_r) && st1_r == $past(st1_r);
  endproperty
  a_batch_keep: assert property (p_batch_keep)
    else $error("batch count or output 1 changed");

  property p_dual_clear;
    key_p && is_dual |=> pv_r == rstv && pvb_r == '0 && !st1_r;
  endproperty
  a_dual_clear: assert property (p_dual_clear)
    else $error("dual clear incomplete");

  property p_alloc;
    ##1 ctrl_out_stage1_o ==
      ($past(ctrl_r.alloc1) ? $past(st2_r) : $past(st1_r));
  endproperty
  a_alloc: assert property (p_alloc)
    else $error("output allocation wrong");

  property p_no_count;
    r1 && !is_dual ##1 r1 && !is_dual |-> pv_r == $past(rstv);
  endproperty
  a_no_count: assert property (p_no_count)
    else $error("counted during reset 1");

  property p_tacho_out;
    is_tacho && !hold && !ctrl_r.omode1 && meas_r >= set1_r
      |=> st1_r ##1 ctrl_out_stage1_o || ctrl_r.alloc1;
  endproperty
  a_tacho_out: assert property (p_tacho_out)
    else $error("tachometer output not set at set value");

endmodule

// ===== testbench/hrc_far_side.sv
// far-side model: count sensors, reset contacts and front key
`timescale 1ns/100ps
module hrc_far_side (
  input  wire logic ref_clk_i,    // system clock
  output logic      count_in_a_o, // sensor a
  output logic      count_in_b_o, // sensor b
  output logic      reset1_o,     // reset contact 1
  output logic      reset2_o,     // reset contact 2
  output logic      reset_key_o   // front key, high pressed
);
  logic       run_a; // sensor a free-running
  logic [1:0] ph;    // free-run phase

  // contacts open and sensors idle at power-up
  initial
  begin
    {count_in_a_o, count_in_b_o, reset1_o, reset2_o, reset_key_o} = 5'h0;
    run_a = 1'b0;
    ph    = 2'h0;
  end

  // period of four keeps each level two cycles, as the inputs need
  always @(posedge ref_clk_i)
    if (run_a)
    begin
      ph           <= ph + 2'h1;
      count_in_a_o <= ph[1];
    end

  // settle time covers two sync flops, logic and output register
  task automatic pins(input logic [2:0] v);
    @(posedge ref_clk_i);
    {reset1_o, reset2_o, reset_key_o} <= v;
    repeat (8) @(posedge ref_clk_i);
  endtask

  // whole pulses only, two cycles high and two low
  task automatic pulse(input logic sel_b, input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i);
      count_in_a_o <= ~sel_b;
      count_in_b_o <= sel_b;
      repeat (2) @(posedge ref_clk_i);
      count_in_a_o <= 1'b0;
      count_in_b_o <= 1'b0;
      @(posedge ref_clk_i);
    end
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule

// ===== testbench/tb.sv
// testbench of the counter reset and hold control
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] CT = hrc_pkg::ADDR_CTRL;
  localparam logic [7:0] S1 = hrc_pkg::ADDR_SET1;
  localparam logic [7:0] S2 = hrc_pkg::ADDR_SET2;
  localparam logic [7:0] PV = hrc_pkg::ADDR_PV;
  localparam logic [7:0] AX = hrc_pkg::ADDR_AUX;
  localparam logic [7:0] PB = hrc_pkg::ADDR_PVB;
  localparam logic [7:0] DU = hrc_pkg::ADDR_DUAL;
  localparam logic [7:0] TA = hrc_pkg::ADDR_TACHO;
  logic        ref_clk_i;
  logic        rst_i;
  logic        a, b, r1, r2, key, o1, o2, ind;
  logic [7:0]  paddr;
  logic        psel, penable, pwrite, pready, pslverr, err_q;
  logic [31:0] pwdata, prdata;
  int          bad_count;
  int          total_checks;

  hrc_top #(.GATE_CYC(50)) i_hrc_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .count_in_a_i(a),
    .count_in_b_i(b), .reset1_i(r1), .reset2_i(r2), .reset_key_i(key),
    .ctrl_out_stage1_o(o1), .ctrl_out_stage2_o(o2), .reset_ind_o(ind),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr));

  hrc_far_side i_hrc_far_side (
    .ref_clk_i(ref_clk_i), .count_in_a_o(a), .count_in_b_o(b),
    .reset1_o(r1), .reset2_o(r2), .reset_key_o(key));

  // 10 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    @(posedge ref_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      bad_count++;
      end_sim();
    end
    rdat = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, ad, d, x);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] x;
    apb(1'b0, ad, 32'h0, x);
    chk(x, e);
  endtask

  // outputs compared as {ctrl_out_stage1, ctrl_out_stage2, indicator}
  task automatic outs(input logic [2:0] e);
    chk({29'h0, o1, o2, ind}, {29'h0, e});
  endtask

  task automatic pn(input logic [2:0] v);
    i_hrc_far_side.pins(v);
  endtask

  task automatic pu(input logic sb, input int n);
    i_hrc_far_side.pulse(sb, n);
  endtask

  // control word; output 2 stays allocated to stage 2
  function automatic logic [31:0] ctl(input logic [2:0] c,
      input logic [1:0] d, input logic aux, input logic al1);
    ctl = {24'h0, 1'b1, al1, aux, d, c};
  endfunction

  task automatic t_regs;
    logic [31:0] x;
    rd(CT, 32'h80);
    rd(S1, 32'ha);
    rd(S2, 32'h14);
    apb(1'b0, 8'h24, 32'h0, x);
    chk({31'h0, err_q}, 32'h1);
    chk(x, 32'h0);
  endtask

  task automatic t_one;
    wr(S1, 32'h2);
    wr(CT, ctl(hrc_pkg::CFG_ONE, hrc_pkg::DIR_UP, 1'b0, 1'b0));
    pn(3'b100);
    pn(3'b000);
    pu(1'b0, 2);
    rd(PV, 32'h2);
    outs(3'b010);
    pn(3'b001);
    rd(PV, 32'h0);
    outs(3'b001);
    pu(1'b0, 1);
    rd(PV, 32'h1);
    pn(3'b000);
    pu(1'b0, 1);
    wr(CT, ctl(hrc_pkg::CFG_ONE, hrc_pkg::DIR_UP, 1'b0, 1'b1));
    repeat (3) @(posedge ref_clk_i);
    outs(3'b110);
    pn(3'b100);
    pu(1'b0, 2);
    rd(PV, 32'h0);
    outs(3'b001);
    pn(3'b000);
  endtask

  task automatic t_down;
    wr(CT, ctl(hrc_pkg::CFG_TWO, hrc_pkg::DIR_DOWN, 1'b0, 1'b0));
    pn(3'b100);
    pn(3'b000);
    rd(PV, 32'h14);
    pu(1'b0, 2);
    rd(PV, 32'h12);
  endtask

  // up/down mode reloads zero; follow mode drops with its comparison
  task automatic t_modes;
    wr(S1, 32'h2);
    wr(CT, ctl(hrc_pkg::CFG_ONE, hrc_pkg::DIR_UPDN, 1'b0, 1'b0) | 32'h200);
    pn(3'b100);
    pn(3'b000);
    pu(1'b0, 2);
    outs(3'b010);
    wr(S1, 32'h5);
    repeat (3) @(posedge ref_clk_i);
    outs(3'b000);
    pn(3'b100);
    rd(PV, 32'h0);
    pn(3'b000);
  endtask

  task automatic t_total;
    wr(S1, 32'h64);
    wr(S2, 32'h64);
    wr(CT, ctl(hrc_pkg::CFG_TOTAL, hrc_pkg::DIR_UP, 1'b1, 1'b0));
    pn(3'b001);
    pn(3'b000);
    wr(CT, ctl(hrc_pkg::CFG_TOTAL, hrc_pkg::DIR_UP, 1'b0, 1'b0));
    pu(1'b0, 3);
    rd(AX, 32'h3);
    pn(3'b001);
    rd(PV, 32'h0);
    rd(AX, 32'h3);
    pn(3'b000);
    wr(CT, ctl(hrc_pkg::CFG_TOTAL, hrc_pkg::DIR_UP, 1'b1, 1'b0));
    pn(3'b001);
    rd(AX, 32'h0);
    pn(3'b000);
  endtask

  task automatic t_batch;
    wr(S1, 32'h1);
    wr(S2, 32'h2);
    wr(CT, ctl(hrc_pkg::CFG_BATCH, hrc_pkg::DIR_UP, 1'b1, 1'b0));
    pn(3'b001);
    pn(3'b000);
    wr(CT, ctl(hrc_pkg::CFG_BATCH, hrc_pkg::DIR_UP, 1'b0, 1'b0));
    pu(1'b0, 2);
    rd(AX, 32'h1);
    outs(3'b110);
    pn(3'b001);
    outs(3'b101);
    rd(AX, 32'h1);
    rd(PV, 32'h0);
    pn(3'b000);
    wr(CT, ctl(hrc_pkg::CFG_BATCH, hrc_pkg::DIR_UP, 1'b1, 1'b0));
    pn(3'b001);
    outs(3'b001);
    rd(AX, 32'h0);
    pn(3'b000);
  endtask

  task automatic t_dual;
    wr(S1, 32'h64);
    wr(S2, 32'h64);
    wr(CT, ctl(hrc_pkg::CFG_DUAL, hrc_pkg::DIR_UP, 1'b0, 1'b0));
    pn(3'b001);
    pn(3'b000);
    pu(1'b0, 2);
    pu(1'b1, 3);
    rd(DU, 32'h5);
    wr(CT, ctl(hrc_pkg::CFG_DUAL, hrc_pkg::DIR_UP, 1'b0, 1'b0) | 32'h400);
    pu(1'b0, 2);
    rd(DU, 32'h1);
    pn(3'b001);
    rd(PV, 32'h0);
    rd(PB, 32'h0);
    rd(DU, 32'h0);
    pn(3'b000);
  endtask

  // gate of 50 cycles sees 12 or 13 edges of a four-cycle period
  task automatic t_tacho;
    logic [31:0] x;
    wr(S1, 32'h1);
    wr(S2, 32'hfffff);
    wr(CT, ctl(hrc_pkg::CFG_TACHO, hrc_pkg::DIR_UP, 1'b0, 1'b0));
    pn(3'b010);
    pu(1'b1, 2);
    rd(PB, 32'h0);
    i_hrc_far_side.run_a <= 1'b1;
    repeat (150) @(posedge ref_clk_i);
    apb(1'b0, TA, 32'h0, x);
    chk({31'h0, x >= 32'hc && x <= 32'hd}, 32'h1);
    outs(3'b100);
    pn(3'b110);
    apb(1'b0, TA, 32'h0, x);
    outs(3'b101);
    repeat (150) @(posedge ref_clk_i);
    rd(TA, x);
    outs(3'b101);
    pn(3'b011);
    repeat (150) @(posedge ref_clk_i);
    rd(TA, x);
    outs(3'b101);
    pn(3'b000);
    i_hrc_far_side.run_a <= 1'b0;
  endtask

  // main sequence
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    rst_i = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_one;
    t_down;
    t_modes;
    t_total;
    t_batch;
    t_dual;
    t_tacho;
    end_sim();
  end
endmodule
